// *** verification/art_timer_chk.sv ***
// Port-level assertion checker for the auto-reload timer.
`timescale 1ns/100ps
module art_timer_chk (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire art_pkg::art_ctrl_t CTRL_I,
  input wire art_pkg::art_wr_t WR_I,
  input wire logic [7:0] COUNT_LOW_BYTE_O,
  input wire logic [7:0] COUNT_HIGH_BYTE_O,
  input wire logic [7:0] RELOAD_LOW_BYTE_O,
  input wire logic [7:0] RELOAD_HIGH_BYTE_O,
  input wire logic HIGH_OVERFLOW_FLAG_O,
  input wire logic LOW_OVERFLOW_FLAG_O,
  input wire logic IRQ_O
);
  import art_pkg::*;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  wire wide = !CTRL_I.split_mode_select && !CTRL_I.capture_enable;
  wire split = CTRL_I.split_mode_select && !CTRL_I.capture_enable;
  wire nocw = !WR_I.count_low_wr && !WR_I.count_high_wr;
  wire go = CTRL_I.run_control && CTRL_I.low_byte_clock_select && nocw;
  wire [15:0] cnt = {COUNT_HIGH_BYTE_O, COUNT_LOW_BYTE_O};
  sequence s_top;
    wide && go && cnt == 16'hFFFF && !WR_I.reload_low_wr && !WR_I.reload_high_wr;
  endsequence
  property p_wrap;
    s_top |=> cnt == $past({RELOAD_HIGH_BYTE_O, RELOAD_LOW_BYTE_O}) && HIGH_OVERFLOW_FLAG_O;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wide wrap wrong");
  property p_step;
    (wide || CTRL_I.capture_enable) && go && cnt != 16'hFFFF |=> cnt == $past(cnt) + 16'h1;
  endproperty
  a_step: assert property (p_step) else $error("count step wrong");
  property p_hold;
    wide && !CTRL_I.run_control && nocw |=> $stable(cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped count moved");
  property p_split_hold;
    split && !CTRL_I.run_control && !WR_I.count_high_wr |=> $stable(COUNT_HIGH_BYTE_O);
  endproperty
  a_split_hold: assert property (p_split_hold) else $error("high byte moved");
  property p_lwrap;
    split && CTRL_I.low_byte_clock_select && COUNT_LOW_BYTE_O == 8'hFF && !WR_I.count_low_wr
      && !WR_I.reload_low_wr |=> COUNT_LOW_BYTE_O == $past(RELOAD_LOW_BYTE_O) && LOW_OVERFLOW_FLAG_O;
  endproperty
  a_lwrap: assert property (p_lwrap) else $error("low wrap wrong");
  property p_hsticky;
    HIGH_OVERFLOW_FLAG_O && !WR_I.high_flag_clr |=> HIGH_OVERFLOW_FLAG_O;
  endproperty
  a_hsticky: assert property (p_hsticky) else $error("high flag lost");
  property p_lsticky;
    LOW_OVERFLOW_FLAG_O && !WR_I.low_flag_clr |=> LOW_OVERFLOW_FLAG_O;
  endproperty
  a_lsticky: assert property (p_lsticky) else $error("low flag lost");
  property p_irq;
    $past(CTRL_I.timer_irq_enable) && HIGH_OVERFLOW_FLAG_O |-> IRQ_O;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_irq_src;
    IRQ_O |-> HIGH_OVERFLOW_FLAG_O || LOW_OVERFLOW_FLAG_O;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq without flag");
  property p_wr;
    WR_I.count_low_wr |=> COUNT_LOW_BYTE_O == $past(WR_I.wdata);
  endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_rld;
    !CTRL_I.capture_enable && !WR_I.reload_high_wr |=> $stable(RELOAD_HIGH_BYTE_O);
  endproperty
  a_rld: assert property (p_rld) else $error("reload changed");
endmodule // art_timer_chk

bind art_timer art_timer_chk i_chk (.REF_CLK_I, .RSTN_I, .CTRL_I, .WR_I, .COUNT_LOW_BYTE_O,
  .COUNT_HIGH_BYTE_O, .RELOAD_LOW_BYTE_O, .RELOAD_HIGH_BYTE_O, .HIGH_OVERFLOW_FLAG_O,
  .LOW_OVERFLOW_FLAG_O, .IRQ_O);

// *** verification/test_auto_reload_timer_with_lfo_capture.sv ***
// Self-checking random bench for the auto-reload timer.
`timescale 1ns/100ps
module test_auto_reload_timer_with_lfo_capture;
  import art_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ext = 1'b0;
  logic lfo = 1'b1;
  logic [1:0] k = 2'h0;
  art_ctrl_t ctrl = '0;
  art_wr_t wr = '0;
  logic [7:0] cl, ch, rl, rh;
  logic hf, lf, irq;
  logic [15:0] r, b, a;
  int failures = 0;
  int samples_checked = 0;
  wire [15:0] cnt = {ch, cl};
  wire [15:0] rld = {rh, rl};
  art_timer i_dut (.REF_CLK_I(clk), .RSTN_I(rstn), .CTRL_I(ctrl), .WR_I(wr), .EXT_OSC_I(ext),
    .LFO_I(lfo), .COUNT_LOW_BYTE_O(cl), .COUNT_HIGH_BYTE_O(ch), .RELOAD_LOW_BYTE_O(rl),
    .RELOAD_HIGH_BYTE_O(rh), .HIGH_OVERFLOW_FLAG_O(hf), .LOW_OVERFLOW_FLAG_O(lf), .IRQ_O(irq));
  initial forever #2.5 clk = ~clk;
  // The oscillator runs free with a period of 8 cycles, so its divided tick is exactly 64 cycles.
  always @(posedge clk)
  begin
    k <= k + 2'h1;
    if (k == 2'h3)
      ext <= ~ext;
  end
  function automatic logic inr(input logic [15:0] v, hi);
    return v > 16'h0 && v < hi;
  endfunction
  task automatic stop_test;
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic setc(input logic [8:0] c);
    @(posedge clk);
    ctrl <= c;
  endtask
  task automatic put(input logic [5:0] m, input logic [7:0] d);
    @(posedge clk);
    wr <= {m, d};
    @(posedge clk);
    wr <= '0;
  endtask
  initial
  begin
    #20000;
    failures++;
    stop_test;
  end
  initial
  begin
    void'($urandom(32'h3E1436AD));
    r = 16'($urandom);
    b = 16'($urandom);
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    cyc(1);
    chk({cnt, rld}, 32'h0);
    chk({hf, lf, irq}, 32'h0);
    put(6'h08, r[7:0]);
    put(6'h04, r[15:8]);
    put(6'h20, 8'hFD);
    put(6'h10, 8'hFF);
    #1;
    chk({cnt, rld}, {16'hFFFD, r});
    setc(9'h035);
    cyc(3);
    chk(cnt, r);
    chk({hf, lf, irq}, 32'h7);
    setc(9'h021);
    cyc(3);
    chk({hf, lf}, 32'h3);
    put(6'h02, 8'h00);
    #1;
    chk({hf, lf, irq}, 32'h3);
    setc(9'h001);
    cyc(2);
    chk({hf, lf, irq}, 32'h2);
    put(6'h31, 8'h00);
    setc(9'h010);
    cyc(2);
    a = cnt;
    cyc(24);
    chk(cnt - a, 32'h2);
    setc(9'h012);
    cyc(2);
    a = cnt;
    cyc(128);
    chk(cnt - a, 32'h2);
    setc(9'h000);
    put(6'h30, 8'hFE);
    put(6'h08, b[7:0]);
    put(6'h04, b[15:8]);
    setc(9'h10D);
    cyc(2);
    chk({cnt, hf, lf, irq}, {8'hFE, b[7:0], 3'h2});
    setc(9'h11D);
    cyc(2);
    chk({ch, hf, lf, irq}, {b[15:8], 3'h7});
    setc(9'h0D5);
    put(6'h33, 8'hFF);
    #1;
    chk(cnt, 32'hFFFF);
    cyc(1);
    chk({cnt, hf, lf}, 32'h0);
    @(posedge clk);
    lfo <= 1'b0;
    cyc(12);
    chk(inr(rld, cnt), 32'h1);
    chk({hf, irq}, 32'h3);
    // With the oscillator source deselected a falling edge must leave the reload pair alone.
    setc(9'h095);
    lfo <= 1'b1;
    cyc(6);
    a = rld;
    @(posedge clk);
    lfo <= 1'b0;
    cyc(8);
    chk(rld, a);
    stop_test;
  end
endmodule // test_auto_reload_timer_with_lfo_capture

// *** verilog/art_cfg.svh ***
// Constants of the auto-reload timer: reset values, counts and options.
`ifndef ART_CFG_SVH
`define ART_CFG_SVH

`define ART_BYTE_RST 8'h00
`define ART_BYTE_MAX 8'hFF
`define ART_DIV12_LAST 4'hB
`define ART_DIV12_RST 4'h0
`define ART_EXT_DIV_LAST 3'h7
`define ART_EXT_DIV_RST 3'h0
`define ART_CAPTURE_FALLING 1'b1
`define ART_SYNC_RST 1'b0

`endif

// *** verilog/art_pkg.sv ***
// Types shared by the auto-reload timer modules.
package art_pkg;

  typedef enum logic [2:0] {
    ART_MODE_WIDE = 3'b001,
    ART_MODE_SPLIT = 3'b010,
    ART_MODE_CAPTURE = 3'b100
  } art_mode_t;

  typedef struct packed {
    logic split_mode_select;
    logic capture_enable;
    logic capture_source_select;
    logic low_overflow_irq_enable;
    logic run_control;
    logic high_byte_clock_select;
    logic low_byte_clock_select;
    logic external_clock_select;
    logic timer_irq_enable;
  } art_ctrl_t;

  typedef struct packed {
    logic count_low_wr;
    logic count_high_wr;
    logic reload_low_wr;
    logic reload_high_wr;
    logic high_flag_clr;
    logic low_flag_clr;
    logic [7:0] wdata;
  } art_wr_t;

  typedef struct packed {
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] reload_low_byte;
    logic [7:0] reload_high_byte;
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic [3:0] div12;
    logic [2:0] ext_div;
    logic ext_prev;
    logic lfo_prev;
    logic irq;
  } art_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } art_sync_t;

endpackage

// *** verilog/art_sync.sv ***
// Three-stage pin synchroniser whose output follows once stages two and three agree.
`timescale 1ns/100ps
`include "art_cfg.svh"

module art_sync #(
  parameter logic INIT = `ART_SYNC_RST
) (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic PIN_I,
  output logic LEVEL_O
);
  import art_pkg::*;

  art_sync_t sync_reg;
  art_sync_t sync_next;

  always_comb
  begin
    sync_next = sync_reg;
    sync_next.s1 = PIN_I;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    // A single-cycle disagreement is treated as a glitch and not passed on.
    if (sync_reg.s2 == sync_reg.s3)
    begin
      sync_next.level = sync_reg.s3;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      sync_reg <= '{s1: INIT, s2: INIT, s3: INIT, level: INIT};
    end
    else
    begin
      sync_reg <= sync_next;
    end
  end

  assign LEVEL_O = sync_reg.level;

endmodule // art_sync

// *** verilog/art_timer.sv ***
// Sixteen-bit auto-reload timer with split byte mode and oscillator capture.
`timescale 1ns/100ps
`include "art_cfg.svh"

module art_timer (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire art_pkg::art_ctrl_t CTRL_I,
  input wire art_pkg::art_wr_t WR_I,
  input wire logic EXT_OSC_I,
  input wire logic LFO_I,
  output logic [7:0] COUNT_LOW_BYTE_O,
  output logic [7:0] COUNT_HIGH_BYTE_O,
  output logic [7:0] RELOAD_LOW_BYTE_O,
  output logic [7:0] RELOAD_HIGH_BYTE_O,
  output logic HIGH_OVERFLOW_FLAG_O,
  output logic LOW_OVERFLOW_FLAG_O,
  output logic IRQ_O
);
  import art_pkg::*;

  art_state_t state_reg;
  art_state_t state_next;
  art_mode_t mode;
  logic ext_level;
  logic lfo_level;
  logic tick_div12;
  logic tick_ext;
  logic tick_low;
  logic tick_high;
  logic lfo_strobe;
  logic low_wrap;
  logic high_wrap;

  // Both slow pins pass the same three-stage synchroniser.
  art_sync #(
    .INIT(`ART_SYNC_RST)
  ) u_ext_sync (
    .REF_CLK_I(REF_CLK_I),
    .RSTN_I(RSTN_I),
    .PIN_I(EXT_OSC_I),
    .LEVEL_O(ext_level)
  );

  art_sync #(
    .INIT(`ART_SYNC_RST)
  ) u_lfo_sync (
    .REF_CLK_I(REF_CLK_I),
    .RSTN_I(RSTN_I),
    .PIN_I(LFO_I),
    .LEVEL_O(lfo_level)
  );

  // Picks the count enable of one byte timer.
  function automatic logic pick_tick(
    input logic fast_sel,
    input logic ext_sel,
    input logic t12,
    input logic t8
  );
    logic result;
    result = 1'b1;
    if (!fast_sel)
    begin
      result = ext_sel ? t8 : t12;
    end
    return result;
  endfunction

  // Capture enable overrides split; the split bit only shapes counting outside capture.
  always_comb
  begin
    if (CTRL_I.capture_enable)
    begin
      mode = ART_MODE_CAPTURE;
    end
    else if (CTRL_I.split_mode_select)
    begin
      mode = ART_MODE_SPLIT;
    end
    else
    begin
      mode = ART_MODE_WIDE;
    end
  end

  // Divider enables run continuously so a mode change never sees a stale phase.
  always_comb
  begin
    tick_div12 = (state_reg.div12 == `ART_DIV12_LAST);
    tick_ext = ext_level && !state_reg.ext_prev && (state_reg.ext_div == `ART_EXT_DIV_LAST);
    tick_low = pick_tick(CTRL_I.low_byte_clock_select, CTRL_I.external_clock_select,
                         tick_div12, tick_ext);
    tick_high = pick_tick(CTRL_I.high_byte_clock_select, CTRL_I.external_clock_select,
                          tick_div12, tick_ext);
    if (`ART_CAPTURE_FALLING)
    begin
      lfo_strobe = state_reg.lfo_prev && !lfo_level;
    end
    else
    begin
      lfo_strobe = !state_reg.lfo_prev && lfo_level;
    end
    low_wrap = (state_reg.count_low_byte == `ART_BYTE_MAX);
    high_wrap = (state_reg.count_high_byte == `ART_BYTE_MAX);
  end

  always_comb
  begin
    state_next = state_reg;

    if (tick_div12)
    begin
      state_next.div12 = `ART_DIV12_RST;
    end
    else
    begin
      state_next.div12 = state_reg.div12 + 4'h1;
    end

    state_next.ext_prev = ext_level;
    if (ext_level && !state_reg.ext_prev)
    begin
      state_next.ext_div = state_reg.ext_div + 3'h1;
    end
    state_next.lfo_prev = lfo_level;

    // Clears come first so that a hardware set in the same cycle wins.
    if (WR_I.high_flag_clr)
    begin
      state_next.high_overflow_flag = 1'b0;
    end
    if (WR_I.low_flag_clr)
    begin
      state_next.low_overflow_flag = 1'b0;
    end

    case (mode)
      ART_MODE_WIDE:
      begin
        if (CTRL_I.run_control && tick_low)
        begin
          if (low_wrap && high_wrap)
          begin
            state_next.count_low_byte = state_reg.reload_low_byte;
            state_next.count_high_byte = state_reg.reload_high_byte;
            state_next.high_overflow_flag = 1'b1;
            state_next.low_overflow_flag = 1'b1;
          end
          else if (low_wrap)
          begin
            state_next.count_low_byte = `ART_BYTE_RST;
            state_next.count_high_byte = state_reg.count_high_byte + 8'h01;
            state_next.low_overflow_flag = 1'b1;
          end
          else
          begin
            state_next.count_low_byte = state_reg.count_low_byte + 8'h01;
          end
        end
      end
      ART_MODE_SPLIT:
      begin
        // The low byte ignores run control by design.
        if (tick_low)
        begin
          if (low_wrap)
          begin
            state_next.count_low_byte = state_reg.reload_low_byte;
            state_next.low_overflow_flag = 1'b1;
          end
          else
          begin
            state_next.count_low_byte = state_reg.count_low_byte + 8'h01;
          end
        end
        if (CTRL_I.run_control && tick_high)
        begin
          if (high_wrap)
          begin
            state_next.count_high_byte = state_reg.reload_high_byte;
            state_next.high_overflow_flag = 1'b1;
          end
          else
          begin
            state_next.count_high_byte = state_reg.count_high_byte + 8'h01;
          end
        end
      end
      ART_MODE_CAPTURE:
      begin
        // No reload here: the reload pair holds the last capture instead.
        if (CTRL_I.run_control && tick_low)
        begin
          {state_next.count_high_byte, state_next.count_low_byte} =
            {state_reg.count_high_byte, state_reg.count_low_byte} + 16'h0001;
        end
      end
      default:
      begin
        state_next = state_reg;
      end
    endcase

    // Software writes to the count bytes win over counting in the same cycle.
    if (WR_I.count_low_wr)
    begin
      state_next.count_low_byte = WR_I.wdata;
    end
    if (WR_I.count_high_wr)
    begin
      state_next.count_high_byte = WR_I.wdata;
    end
    if (WR_I.reload_low_wr)
    begin
      state_next.reload_low_byte = WR_I.wdata;
    end
    if (WR_I.reload_high_wr)
    begin
      state_next.reload_high_byte = WR_I.wdata;
    end

    // A capture beats a software reload write, since the measurement cannot be repeated.
    if (mode == ART_MODE_CAPTURE && CTRL_I.capture_source_select && lfo_strobe)
    begin
      state_next.reload_low_byte = state_reg.count_low_byte;
      state_next.reload_high_byte = state_reg.count_high_byte;
      state_next.high_overflow_flag = 1'b1;
    end

    // Low flag only raises the request when its own enable is set as well.
    state_next.irq = CTRL_I.timer_irq_enable &&
                     (state_next.high_overflow_flag ||
                      (CTRL_I.low_overflow_irq_enable && state_next.low_overflow_flag));
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      state_reg.count_low_byte <= `ART_BYTE_RST;
      state_reg.count_high_byte <= `ART_BYTE_RST;
      state_reg.reload_low_byte <= `ART_BYTE_RST;
      state_reg.reload_high_byte <= `ART_BYTE_RST;
      state_reg.high_overflow_flag <= 1'b0;
      state_reg.low_overflow_flag <= 1'b0;
      state_reg.div12 <= `ART_DIV12_RST;
      state_reg.ext_div <= `ART_EXT_DIV_RST;
      state_reg.ext_prev <= `ART_SYNC_RST;
      state_reg.lfo_prev <= `ART_SYNC_RST;
      state_reg.irq <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign COUNT_LOW_BYTE_O = state_reg.count_low_byte;
  assign COUNT_HIGH_BYTE_O = state_reg.count_high_byte;
  assign RELOAD_LOW_BYTE_O = state_reg.reload_low_byte;
  assign RELOAD_HIGH_BYTE_O = state_reg.reload_high_byte;
  assign HIGH_OVERFLOW_FLAG_O = state_reg.high_overflow_flag;
  assign LOW_OVERFLOW_FLAG_O = state_reg.low_overflow_flag;
  assign IRQ_O = state_reg.irq;

endmodule // art_timer
